// ==== verilog/spio_defs.vh ====
// Constants for the shared parallel I/O port block
`ifndef SPIO_DEFS_VH
`define SPIO_DEFS_VH
`define SPIO_PORT_A 3'h0
`define SPIO_PORT_B 3'h1
`define SPIO_PORT_C 3'h2
`define SPIO_PORT_D 3'h3
`define SPIO_PORT_E 3'h4
`define SPIO_PORT_G 3'h5
`define SPIO_W_A 8
`define SPIO_W_B 8
`define SPIO_W_C 8
`define SPIO_W_D 5
`define SPIO_W_E 6
`define SPIO_W_G 4
`define SPIO_RST_BYTE 8'h00
`define SPIO_RST_BKGD_EN 1'b1
`define SPIO_C_SCI_TX 0
`define SPIO_C_SCI_RX 1
`define SPIO_C_SDA 2
`define SPIO_C_SCL 3
`define SPIO_D_T1_LO 0
`define SPIO_D_T1_HI 2
`define SPIO_D_T2_LO 3
`define SPIO_D_T2_HI 4
`define SPIO_E_SCI_TX 0
`define SPIO_E_SCI_RX 1
`define SPIO_E_SS 2
`define SPIO_E_MISO 3
`define SPIO_E_MOSI 4
`define SPIO_E_SCK 5
`define SPIO_G_BKGD 0
`define SPIO_G_OSC_LO 1
`define SPIO_G_OSC_HI 2
`endif

// ==== verilog/spio_pin_mux.v ====
// One 8-bit slice of pad muxing: peripheral override, pullup, slew, read-back
`timescale 1ns/1ps
module spio_pin_mux (
    // Port control
    input wire [7:0] LATCH,
    input wire [7:0] DIR,
    input wire [7:0] PULL_EN,
    input wire [7:0] SLEW_EN,
    // Peripheral ownership
    input wire [7:0] PERIPH_OWN,
    input wire [7:0] PERIPH_DRIVE,
    input wire [7:0] PERIPH_OUT,
    input wire [7:0] FORCE_IN,
    // Pad
    input wire [7:0] PAD_IN,
    output wire [7:0] PAD_OUT,
    output wire [7:0] PAD_OE_N,
    output wire [7:0] PAD_PULL,
    output wire [7:0] PAD_SLEW,
    output wire [7:0] READ_DATA
);
    wire [7:0] gpio_drive;
    wire [7:0] drive;

    assign gpio_drive = DIR & ~PERIPH_OWN & ~FORCE_IN;
    assign drive = gpio_drive | (PERIPH_OWN & PERIPH_DRIVE);
    assign PAD_OE_N = ~drive;
    assign PAD_OUT = (PERIPH_OWN & PERIPH_OUT) | (~PERIPH_OWN & LATCH);
    // Pullup for inputs, peripheral inputs included while direction is 0
    assign PAD_PULL = PULL_EN & ~DIR & ~drive;
    assign PAD_SLEW = SLEW_EN & drive;
    assign READ_DATA = (DIR & LATCH) | (~DIR & PAD_IN);
endmodule

// ==== verilog/spio_ports.v ====
// Six shared parallel I/O ports with peripheral pin arbitration
// Function
// - Six ports, 39 pins; port G bit 0 is output only.
// - Reset clears direction and pullup bits; pins come up high-impedance inputs.
// - Background pin enabled after reset; G0 no output until enable cleared.
// - Port A keyboard inputs are forced to act as inputs.
// - Port B analog-selected pins are forced to act as inputs.
// - Second serial port owns C0 transmit, C1 receive, controls direction.
// - Two-wire unit owns C2 data and C3 clock, controls direction.
// - Port D has five pins; enabled timers control their pins' direction.
// - Second timer uses D4 and D3; D3 alone as external clock.
// - First timer uses D2 to D0; D0 alone as external clock.
// - Port E six pins; first serial port owns E0 transmit, E1 receive.
// - SPI owns E2 select, E3 MISO, E4 MOSI, E5 clock.
// - Port G four pins; background and oscillator functions control their pins.
// - Background function keeps G0 pullup on regardless of pullup bit.
// - G0 is mode select during reset, background pin afterwards.
// - Clock generator may take G2 and G1 as oscillator pins.
// - Each pin direction bit enables driver when 1, input when 0.
// - Data reads give pin level when direction 0, latch when 1.
// - Writes always update latch; latch drives pin only as plain output.
// - Direction bit still selects read source under peripheral override.
// - Reading G0 returns the level on the output pin.
// - Pullup only when enabled and pin is input, peripheral inputs too while direction is 0.
// - Rising-edge keyboard inputs A7 to A4 get pulldown instead of pullup.
// - Slew limiting only when enabled and pin driven as output.
`timescale 1ns/1ps
`include "spio_defs.vh"
module spio_ports (
    // Clock and reset
    input wire CORE_CLK,
    input wire RESET,
    // Register write port
    input wire WR_EN,
    input wire [2:0] WR_PORT,
    input wire [1:0] WR_SEL,
    input wire [7:0] WR_DATA,
    input wire BKGD_EN_WR,
    input wire BKGD_EN_DATA,
    // Register read port
    input wire [2:0] RD_PORT,
    output reg [7:0] RD_LATCH,
    output reg [7:0] RD_DIR,
    output reg [7:0] RD_PULL,
    output reg [7:0] RD_SLEW,
    output reg [7:0] RD_DATA,
    output wire BACKGROUND_PIN_ENABLE,
    output reg MODE_SELECT_CAPTURED,
    // Peripheral enables and selects
    input wire [7:0] KEY_PIN_EN,
    input wire [3:0] KEY_RISING,
    input wire [7:0] ADC_PIN_EN,
    input wire SER2_EN,
    input wire SER2_TX,
    input wire TWI_EN,
    input wire TWI_SDA_OUT,
    input wire TWI_SDA_DRIVE,
    input wire TWI_SCL_OUT,
    input wire TWI_SCL_DRIVE,
    input wire [2:0] TMR1_PIN_EN,
    input wire [2:0] TMR1_PIN_DRIVE,
    input wire [2:0] TMR1_PIN_OUT,
    input wire [1:0] TMR2_PIN_EN,
    input wire [1:0] TMR2_PIN_DRIVE,
    input wire [1:0] TMR2_PIN_OUT,
    input wire SER1_EN,
    input wire SER1_TX,
    input wire SPI_EN,
    input wire [3:0] SPI_PIN_DRIVE,
    input wire [3:0] SPI_PIN_OUT,
    input wire OSC_EN,
    input wire BKGD_OUT,
    input wire BKGD_DRIVE,
    // Pads
    input wire [7:0] PTA_IN,
    output wire [7:0] PTA_OUT,
    output wire [7:0] PTA_OE_N,
    output wire [7:0] PTA_PULLUP,
    output wire [3:0] PTA_PULLDOWN,
    output wire [7:0] PTA_SLEW,
    input wire [7:0] PTB_IN,
    output wire [7:0] PTB_OUT,
    output wire [7:0] PTB_OE_N,
    output wire [7:0] PTB_PULLUP,
    output wire [7:0] PTB_SLEW,
    input wire [7:0] PTC_IN,
    output wire [7:0] PTC_OUT,
    output wire [7:0] PTC_OE_N,
    output wire [7:0] PTC_PULLUP,
    output wire [7:0] PTC_SLEW,
    input wire [4:0] PTD_IN,
    output wire [4:0] PTD_OUT,
    output wire [4:0] PTD_OE_N,
    output wire [4:0] PTD_PULLUP,
    output wire [4:0] PTD_SLEW,
    input wire [5:0] PTE_IN,
    output wire [5:0] PTE_OUT,
    output wire [5:0] PTE_OE_N,
    output wire [5:0] PTE_PULLUP,
    output wire [5:0] PTE_SLEW,
    input wire [3:0] PTG_IN,
    output wire [3:0] PTG_OUT,
    output wire [3:0] PTG_OE_N,
    output wire [3:0] PTG_PULLUP,
    output wire [3:0] PTG_SLEW,
    // Peripheral receive taps
    output wire SER2_RX,
    output wire TWI_SDA_IN,
    output wire TWI_SCL_IN,
    output wire [4:0] TMR_PIN_IN,
    output wire SER1_RX,
    output wire [3:0] SPI_PIN_IN,
    output wire BKGD_IN
);
    // Storage: index is port number, 0..5
    reg [7:0] port_data_latch_ff [0:5];
    reg [7:0] port_direction_bits_ff [0:5];
    reg [7:0] port_pullup_enable_ff [0:5];
    reg [7:0] port_slew_enable_ff [0:5];
    reg background_pin_enable_ff;
    reg in_reset_ff;
    integer i;

    function [7:0] port_mask;
        input [2:0] p;
        begin
            if (p == `SPIO_PORT_D) begin
                port_mask = 8'h1F;
            end else if (p == `SPIO_PORT_E) begin
                port_mask = 8'h3F;
            end else if (p == `SPIO_PORT_G) begin
                port_mask = 8'h0F;
            end else if (p > `SPIO_PORT_G) begin
                port_mask = 8'h00;
            end else begin
                port_mask = 8'hFF;
            end
        end
    endfunction

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            for (i = 0; i < 6; i = i + 1) begin
                port_data_latch_ff[i] <= `SPIO_RST_BYTE;
                port_direction_bits_ff[i] <= `SPIO_RST_BYTE;
                port_pullup_enable_ff[i] <= `SPIO_RST_BYTE;
                port_slew_enable_ff[i] <= `SPIO_RST_BYTE;
            end
            background_pin_enable_ff <= `SPIO_RST_BKGD_EN;
            in_reset_ff <= 1'b1;
        end else begin
            in_reset_ff <= 1'b0;
            if (WR_EN && port_mask(WR_PORT) != 8'h00) begin
                if (WR_SEL == 2'h0) begin
                    port_data_latch_ff[WR_PORT] <= WR_DATA & port_mask(WR_PORT);
                end else if (WR_SEL == 2'h1) begin
                    port_direction_bits_ff[WR_PORT] <= WR_DATA & port_mask(WR_PORT);
                end else if (WR_SEL == 2'h2) begin
                    port_pullup_enable_ff[WR_PORT] <= WR_DATA & port_mask(WR_PORT);
                end else begin
                    port_slew_enable_ff[WR_PORT] <= WR_DATA & port_mask(WR_PORT);
                end
            end
            if (BKGD_EN_WR) begin
                background_pin_enable_ff <= BKGD_EN_DATA;
            end
        end
    end

    // Mode select level caught on the last reset cycle
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            MODE_SELECT_CAPTURED <= PTG_IN[`SPIO_G_BKGD];
        end
    end

    assign BACKGROUND_PIN_ENABLE = background_pin_enable_ff;

    // Ownership, drive and value per port, padded to 8 bits
    wire [7:0] own [0:5];
    wire [7:0] pdrv [0:5];
    wire [7:0] pout [0:5];
    wire [7:0] fin [0:5];
    wire [7:0] pin_in [0:5];
    wire [7:0] m_out [0:5];
    wire [7:0] m_oe_n [0:5];
    wire [7:0] m_pull [0:5];
    wire [7:0] m_slew [0:5];
    wire [7:0] m_rd [0:5];
    wire bkgd_active;

    assign bkgd_active = background_pin_enable_ff | in_reset_ff;

    assign own[0] = 8'h00;
    assign pdrv[0] = 8'h00;
    assign pout[0] = 8'h00;
    assign fin[0] = KEY_PIN_EN;
    assign own[1] = 8'h00;
    assign pdrv[1] = 8'h00;
    assign pout[1] = 8'h00;
    assign fin[1] = ADC_PIN_EN;
    assign own[2] = {4'h0, TWI_EN, TWI_EN, SER2_EN, SER2_EN};
    assign pdrv[2] = {4'h0, TWI_SCL_DRIVE, TWI_SDA_DRIVE, 1'b0, 1'b1};
    assign pout[2] = {4'h0, TWI_SCL_OUT, TWI_SDA_OUT, 1'b0, SER2_TX};
    assign fin[2] = 8'h00;
    assign own[3] = {3'h0, TMR2_PIN_EN, TMR1_PIN_EN};
    assign pdrv[3] = {3'h0, TMR2_PIN_DRIVE, TMR1_PIN_DRIVE};
    assign pout[3] = {3'h0, TMR2_PIN_OUT, TMR1_PIN_OUT};
    assign fin[3] = 8'h00;
    assign own[4] = {2'h0, {4{SPI_EN}}, SER1_EN, SER1_EN};
    assign pdrv[4] = {2'h0, SPI_PIN_DRIVE, 1'b0, 1'b1};
    assign pout[4] = {2'h0, SPI_PIN_OUT, 1'b0, SER1_TX};
    assign fin[4] = 8'h00;
    // Port G bit 0 is output only: background function or its latch drives it
    assign own[5] = {5'h00, OSC_EN, OSC_EN, 1'b1};
    assign pdrv[5] = {5'h00, 2'h0, bkgd_active ? (BKGD_DRIVE & ~in_reset_ff) : 1'b1};
    assign pout[5] = {5'h00, 2'h0, bkgd_active ? BKGD_OUT : port_data_latch_ff[5][0]};
    assign fin[5] = 8'h00;

    assign pin_in[0] = PTA_IN;
    assign pin_in[1] = PTB_IN;
    assign pin_in[2] = PTC_IN;
    assign pin_in[3] = {3'h0, PTD_IN};
    assign pin_in[4] = {2'h0, PTE_IN};
    assign pin_in[5] = {4'h0, PTG_IN[3:1], PTG_OUT[0]};

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : mux
            spio_pin_mux u_mux (
                .LATCH(port_data_latch_ff[g]),
                .DIR(port_direction_bits_ff[g]),
                .PULL_EN(port_pullup_enable_ff[g]),
                .SLEW_EN(port_slew_enable_ff[g]),
                .PERIPH_OWN(own[g]),
                .PERIPH_DRIVE(pdrv[g]),
                .PERIPH_OUT(pout[g]),
                .FORCE_IN(fin[g]),
                .PAD_IN(pin_in[g]),
                .PAD_OUT(m_out[g]),
                .PAD_OE_N(m_oe_n[g]),
                .PAD_PULL(m_pull[g]),
                .PAD_SLEW(m_slew[g]),
                .READ_DATA(m_rd[g])
            );
        end
    endgenerate

    assign PTA_OUT = m_out[0];
    assign PTA_OE_N = m_oe_n[0];
    assign PTA_PULLUP = {m_pull[0][7:4] & ~(KEY_PIN_EN[7:4] & KEY_RISING), m_pull[0][3:0]};
    assign PTA_PULLDOWN = m_pull[0][7:4] & KEY_PIN_EN[7:4] & KEY_RISING;
    assign PTA_SLEW = m_slew[0] & ~KEY_PIN_EN;
    assign PTB_OUT = m_out[1];
    assign PTB_OE_N = m_oe_n[1];
    assign PTB_PULLUP = m_pull[1];
    assign PTB_SLEW = m_slew[1];
    assign PTC_OUT = m_out[2];
    assign PTC_OE_N = m_oe_n[2];
    assign PTC_PULLUP = m_pull[2];
    assign PTC_SLEW = m_slew[2];
    assign PTD_OUT = m_out[3][4:0];
    assign PTD_OE_N = m_oe_n[3][4:0];
    assign PTD_PULLUP = m_pull[3][4:0];
    assign PTD_SLEW = m_slew[3][4:0];
    assign PTE_OUT = m_out[4][5:0];
    assign PTE_OE_N = m_oe_n[4][5:0];
    assign PTE_PULLUP = m_pull[4][5:0];
    assign PTE_SLEW = m_slew[4][5:0];
    assign PTG_OUT = m_out[5][3:0];
    assign PTG_OE_N = m_oe_n[5][3:0];
    assign PTG_PULLUP = {m_pull[5][3:1], m_pull[5][0] | bkgd_active};
    assign PTG_SLEW = m_slew[5][3:0];

    assign SER2_RX = PTC_IN[`SPIO_C_SCI_RX];
    assign TWI_SDA_IN = PTC_IN[`SPIO_C_SDA];
    assign TWI_SCL_IN = PTC_IN[`SPIO_C_SCL];
    assign TMR_PIN_IN = PTD_IN;
    assign SER1_RX = PTE_IN[`SPIO_E_SCI_RX];
    assign SPI_PIN_IN = PTE_IN[`SPIO_E_SCK:`SPIO_E_SS];
    assign BKGD_IN = PTG_IN[`SPIO_G_BKGD];

    // Registered read-back of the selected port
    always @(posedge CORE_CLK) begin
        if (RESET || port_mask(RD_PORT) == 8'h00) begin
            RD_LATCH <= 8'h00;
            RD_DIR <= 8'h00;
            RD_PULL <= 8'h00;
            RD_SLEW <= 8'h00;
            RD_DATA <= 8'h00;
        end else begin
            RD_LATCH <= port_data_latch_ff[RD_PORT];
            RD_DIR <= port_direction_bits_ff[RD_PORT];
            RD_PULL <= port_pullup_enable_ff[RD_PORT];
            RD_SLEW <= port_slew_enable_ff[RD_PORT];
            RD_DATA <= m_rd[RD_PORT] & port_mask(RD_PORT);
        end
    end
endmodule

// ==== tb/spio_ports_props.sv ====
// Property checker for the shared parallel I/O port block
`timescale 1ns/1ps
module spio_props (
    // Clock and reset
    input logic CORE_CLK,
    input logic RESET,
    // Control
    input logic WR_EN,
    input logic [2:0] WR_PORT,
    input logic [1:0] WR_SEL,
    input logic [7:0] WR_DATA,
    input logic BKGD_EN_WR,
    input logic BKGD_EN_DATA,
    input logic BACKGROUND_PIN_ENABLE,
    // Peripherals
    input logic [7:0] KEY_PIN_EN,
    input logic [7:0] ADC_PIN_EN,
    input logic SER2_EN,
    input logic SER2_TX,
    input logic SER2_RX,
    // Pads
    input logic [7:0] PTA_OE_N,
    input logic [7:0] PTA_PULLUP,
    input logic [7:0] PTA_SLEW,
    input logic [7:0] PTB_OE_N,
    input logic [7:0] PTC_IN,
    input logic [7:0] PTC_OUT,
    input logic [7:0] PTC_OE_N,
    input logic [3:0] PTG_OE_N,
    input logic [3:0] PTG_PULLUP
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);
    // Direction write to port A with no keyboard override
    sequence s_dir_a;
        WR_EN && WR_PORT == 3'h0 && WR_SEL == 2'h1 ##1 KEY_PIN_EN == 8'h00;
    endsequence
    chk_reset_pins_idle: assert property ($fell(RESET) |-> BACKGROUND_PIN_ENABLE && PTA_OE_N == 8'hFF)
        else $error("pins not idle after reset");
    chk_bkgd_enable_write: assert property (BKGD_EN_WR |=> BACKGROUND_PIN_ENABLE == $past(BKGD_EN_DATA))
        else $error("background enable not loaded");
    chk_dir_drives_pin: assert property (s_dir_a |-> PTA_OE_N == ~$past(WR_DATA))
        else $error("direction write did not reach driver");
    chk_key_forced_input: assert property ((KEY_PIN_EN & ~PTA_OE_N) == 8'h00)
        else $error("keyboard pin driven");
    chk_adc_forced_input: assert property ((ADC_PIN_EN & ~PTB_OE_N) == 8'h00)
        else $error("analog pin driven");
    chk_ser2_tx_owned: assert property (SER2_EN |-> !PTC_OE_N[0] && PTC_OUT[0] == SER2_TX && PTC_OE_N[1])
        else $error("serial pins not owned");
    chk_ser2_rx_tap: assert property (SER2_RX == PTC_IN[1])
        else $error("serial receive tap wrong");
    chk_bkgd_pull_on: assert property (BACKGROUND_PIN_ENABLE |-> PTG_PULLUP[0])
        else $error("background pullup off");
    chk_pull_input_only: assert property ((PTA_PULLUP & ~PTA_OE_N) == 8'h00)
        else $error("pullup on driven pin");
    chk_slew_output_only: assert property ((PTA_SLEW & PTA_OE_N) == 8'h00)
        else $error("slew on undriven pin");
    chk_g0_output_only: assert property (!BACKGROUND_PIN_ENABLE |-> !PTG_OE_N[0])
        else $error("port G bit 0 not driven");
endmodule
bind spio_ports spio_props spio_props_i (.*);

// ==== tb/spio_pads.sv ====
// Board pin model: pad levels from drivers, pulls and outside sources
`timescale 1ns/1ps
module spio_pads (
    // Clock
    input logic CORE_CLK,
    // Device side
    input logic [38:0] DRV_N,
    input logic [38:0] OUT,
    input logic [38:0] PULL_UP,
    input logic [38:0] PULL_DN,
    // Board side
    input logic [38:0] EXT_EN,
    input logic [38:0] EXT_V,
    output logic [38:0] PIN
);
    logic toggle_ff = 1'h0;
    always @(posedge CORE_CLK) toggle_ff <= ~toggle_ff;
    // Floating pins wander so a stale level never reads back
    always_comb
        for (int i = 0; i < 39; i++)
            PIN[i] = !DRV_N[i] ? OUT[i] : EXT_EN[i] ? EXT_V[i] : PULL_UP[i] ? 1'h1 : PULL_DN[i] ? 1'h0 : toggle_ff;
endmodule

// ==== tb/tb_spio_ports.sv ====
// Testbench for the shared parallel I/O port block
`timescale 1ns/1ps
module tb_spio_ports;
    localparam int OFF[7] = '{0, 8, 16, 24, 29, 35, 39};
    localparam int W[7] = '{8, 8, 8, 5, 6, 4, 0};
    logic CORE_CLK = 1'h0, RESET = 1'h1, WR_EN = 1'h0, BKGD_EN_WR = 1'h0, BKGD_EN_DATA = 1'h0;
    logic [2:0] WR_PORT = 3'h0, RD_PORT = 3'h0;
    logic [1:0] WR_SEL = 2'h0;
    logic [7:0] WR_DATA = 8'h00, RD_LATCH, RD_DIR, RD_PULL, RD_SLEW, RD_DATA, KEY_PIN_EN, ADC_PIN_EN;
    logic BACKGROUND_PIN_ENABLE, MODE_SELECT_CAPTURED, SER2_EN, SER2_TX, TWI_EN, TWI_SDA_OUT, TWI_SDA_DRIVE;
    logic TWI_SCL_OUT, TWI_SCL_DRIVE, SER1_EN, SER1_TX, SPI_EN, OSC_EN, BKGD_OUT, BKGD_DRIVE, bk;
    logic SER2_RX, TWI_SDA_IN, TWI_SCL_IN, SER1_RX, BKGD_IN;
    logic [3:0] KEY_RISING, SPI_PIN_DRIVE, SPI_PIN_OUT, SPI_PIN_IN, PTA_PULLDOWN, e_pd;
    logic [2:0] TMR1_PIN_EN, TMR1_PIN_DRIVE, TMR1_PIN_OUT;
    logic [1:0] TMR2_PIN_EN, TMR2_PIN_DRIVE, TMR2_PIN_OUT;
    logic [7:0] PTA_IN, PTA_OUT, PTA_OE_N, PTA_PULLUP, PTA_SLEW;
    logic [7:0] PTB_IN, PTB_OUT, PTB_OE_N, PTB_PULLUP, PTB_SLEW;
    logic [7:0] PTC_IN, PTC_OUT, PTC_OE_N, PTC_PULLUP, PTC_SLEW;
    logic [4:0] PTD_IN, PTD_OUT, PTD_OE_N, PTD_PULLUP, PTD_SLEW, TMR_PIN_IN;
    logic [5:0] PTE_IN, PTE_OUT, PTE_OE_N, PTE_PULLUP, PTE_SLEW;
    logic [3:0] PTG_IN, PTG_OUT, PTG_OE_N, PTG_PULLUP, PTG_SLEW;
    logic [7:0] lat[7], dir[7], pe[7], se[7];
    logic [38:0] e_oe, e_out, e_pu, e_sl, pin, ext_en = 39'h0, ext_v = 39'h0;
    logic [31:0] seed = 32'h0001_4344;
    int err_count = 0;
    int n_compared = 0;
    wire [38:0] oe = {PTG_OE_N, PTE_OE_N, PTD_OE_N, PTC_OE_N, PTB_OE_N, PTA_OE_N};
    wire [38:0] out = {PTG_OUT, PTE_OUT, PTD_OUT, PTC_OUT, PTB_OUT, PTA_OUT};
    wire [38:0] pu = {PTG_PULLUP, PTE_PULLUP, PTD_PULLUP, PTC_PULLUP, PTB_PULLUP, PTA_PULLUP};
    wire [38:0] sl = {PTG_SLEW, PTE_SLEW, PTD_SLEW, PTC_SLEW, PTB_SLEW, PTA_SLEW};
    assign {PTG_IN, PTE_IN, PTD_IN, PTC_IN, PTB_IN, PTA_IN} = pin;
    spio_ports spio_ports_i (.*);
    spio_pads spio_pads_i (.CORE_CLK(CORE_CLK), .DRV_N(oe), .OUT(out), .PULL_UP(pu),
        .PULL_DN({31'h0, PTA_PULLDOWN, 4'h0}), .EXT_EN(ext_en), .EXT_V(ext_v), .PIN(pin));
    always #10 CORE_CLK = ~CORE_CLK;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] slice(logic [38:0] b, int p);
        return 8'((b >> OFF[p]) & ((39'h1 << W[p]) - 39'h1));
    endfunction
    task automatic cmp(logic [38:0] got, logic [38:0] exp, string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic set_per(logic [55:0] v);
        {KEY_PIN_EN, KEY_RISING, ADC_PIN_EN, SER2_EN, SER2_TX, TWI_EN, TWI_SDA_OUT, TWI_SDA_DRIVE, TWI_SCL_OUT,
            TWI_SCL_DRIVE, TMR1_PIN_EN, TMR1_PIN_DRIVE, TMR1_PIN_OUT, TMR2_PIN_EN, TMR2_PIN_DRIVE, TMR2_PIN_OUT,
            SER1_EN, SER1_TX, SPI_EN, SPI_PIN_DRIVE, SPI_PIN_OUT, OSC_EN, BKGD_OUT, BKGD_DRIVE} <= v;
    endtask
    task automatic wr(int p, int s, logic [7:0] d);
        @(posedge CORE_CLK);
        WR_EN <= 1'h1;
        WR_PORT <= 3'(p);
        WR_SEL <= 2'(s);
        WR_DATA <= d;
        @(posedge CORE_CLK);
        WR_EN <= 1'h0;
        d &= slice('1, p);
        case (s)
            0: lat[p] = d;
            1: dir[p] = d;
            2: pe[p] = d;
            default: se[p] = d;
        endcase
    endtask
    task automatic bkgd(logic v);
        @(posedge CORE_CLK);
        BKGD_EN_WR <= 1'h1;
        BKGD_EN_DATA <= v;
        @(posedge CORE_CLK);
        BKGD_EN_WR <= 1'h0;
        bk = v;
    endtask
    task automatic model();
        logic [7:0] own[7], drv[7], po[7], fin[7], d;
        logic [3:0] rise;
        own = '{default: 8'h00};
        drv = '{default: 8'h00};
        po = '{default: 8'h00};
        fin = '{default: 8'h00};
        fin[0] = KEY_PIN_EN;
        fin[1] = ADC_PIN_EN;
        if (SER2_EN) begin
            own[2][1:0] = 2'h3;
            drv[2][0] = 1'h1;
            po[2][0] = SER2_TX;
        end
        if (TWI_EN) begin
            own[2][3:2] = 2'h3;
            drv[2][3:2] = {TWI_SCL_DRIVE, TWI_SDA_DRIVE};
            po[2][3:2] = {TWI_SCL_OUT, TWI_SDA_OUT};
        end
        own[3] = {3'h0, TMR2_PIN_EN, TMR1_PIN_EN};
        drv[3] = own[3] & {3'h0, TMR2_PIN_DRIVE, TMR1_PIN_DRIVE};
        po[3] = {3'h0, TMR2_PIN_OUT, TMR1_PIN_OUT};
        if (SER1_EN) begin
            own[4][1:0] = 2'h3;
            drv[4][0] = 1'h1;
            po[4][0] = SER1_TX;
        end
        if (SPI_EN) begin
            own[4][5:2] = 4'hF;
            drv[4][5:2] = SPI_PIN_DRIVE;
            po[4][5:2] = SPI_PIN_OUT;
        end
        own[5] = {5'h0, OSC_EN, OSC_EN, 1'h1};
        drv[5][0] = bk ? BKGD_DRIVE : 1'h1;
        po[5][0] = bk ? BKGD_OUT : lat[5][0];
        rise = KEY_PIN_EN[7:4] & KEY_RISING;
        {e_oe, e_out, e_pu, e_sl} = '0;
        for (int p = 0; p < 6; p++) begin
            d = (own[p] & drv[p]) | (~own[p] & dir[p] & ~fin[p]);
            e_oe |= 39'(~d & slice('1, p)) << OFF[p];
            e_out |= 39'((own[p] & po[p]) | (~own[p] & lat[p])) << OFF[p];
            e_pu |= 39'(pe[p] & ~dir[p] & ~d) << OFF[p];
            e_sl |= 39'(se[p] & d) << OFF[p];
        end
        e_pu[35] = e_pu[35] | bk;
        e_pu[7:4] = e_pu[7:4] & ~rise;
        e_pd = pe[0][7:4] & ~dir[0][7:4] & rise;
    endtask
    task automatic check();
        logic [7:0] pv, rd;
        for (int p = 0; p < 7; p++) begin
            @(posedge CORE_CLK);
            RD_PORT <= 3'(p);
            @(negedge CORE_CLK);
            model();
            pv = slice(pin, p);
            cmp(oe, e_oe, "drive enables");
            cmp(out & ~e_oe, e_out & ~e_oe, "pad values");
            cmp(pu, e_pu, "pullups");
            cmp(sl, e_sl, "slew");
            cmp(PTA_PULLDOWN, e_pd, "pulldowns");
            cmp({SER2_RX, TWI_SDA_IN, TWI_SCL_IN, TMR_PIN_IN, SER1_RX, SPI_PIN_IN, BKGD_IN},
                {pin[17], pin[18], pin[19], pin[28:24], pin[30], pin[34:31], pin[35]}, "taps");
            rd = (dir[p] & lat[p]) | (~dir[p] & pv);
            if (p == 5 && !dir[5][0]) rd[0] = e_out[35];
            @(negedge CORE_CLK);
            cmp(RD_DATA, rd, "read data");
            cmp({RD_LATCH, RD_DIR, RD_PULL, RD_SLEW, BACKGROUND_PIN_ENABLE},
                {lat[p], dir[p], pe[p], se[p], bk}, "registers");
        end
    endtask
    task automatic reset_run(logic v);
        set_per(56'h0);
        ext_en <= 39'h08_0000_0000;
        ext_v <= {3'h0, v, 35'h0};
        @(posedge CORE_CLK);
        RESET <= 1'h1;
        repeat (10) @(posedge CORE_CLK);
        RESET <= 1'h0;
        lat = '{default: 8'h00};
        dir = '{default: 8'h00};
        pe = '{default: 8'h00};
        se = '{default: 8'h00};
        bk = 1'h1;
        check();
        cmp(MODE_SELECT_CAPTURED, v, "mode capture");
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        int p;
        reset_run(1'h0);
        for (int i = 0; i < 40; i++) begin
            p = int'(rnd() % 7);
            wr(p, 0, 8'(rnd())); // data before direction
            wr(p, 1, 8'(rnd()));
            wr(p, 2 + i % 2, 8'(rnd()));
            if (i % 4 == 1) bkgd(1'(rnd()));
            ext_en <= 39'({rnd(), rnd()});
            ext_v <= 39'({rnd(), rnd()});
            set_per(i < 16 ? 56'h0 : 56'({rnd(), rnd()}));
            check();
        end
        reset_run(1'h1);
        report_and_stop();
    end
    initial begin
        repeat (30000) @(posedge CORE_CLK);
        err_count++;
        report_and_stop();
    end
endmodule
